// ===== design/ssom_mapper.sv
// Servo status output mapper: per-slot status function selection
`timescale 1ns/10ps
`default_nettype none
`include "ssom_cfg.svh"

// Contract
// - Code 0x01 drives the slot high with both powers present and no alarm.
// - Code 0x02 drives the slot high while the servo is enabled and no alarm.
// - Code 0x03 drives the slot high while speed is below the zero-speed threshold.
// - Code 0x04 drives the slot high while speed is above the target-speed threshold.
// - Code 0x05 drives the slot high in pulse-train mode while deviation is below the in-position range.
// - Code 0x06 drives the slot high during torque limiting, except in torque modes.
// - Code 0x07 drives the slot high on any alarm, not on limit, comms or undervoltage.
// - Code 0x08 gives brake release, rising after servo on and falling after servo off with two delays, the off delay cut short at zero speed.
// - Code 0x10 drives the slot high once overload time exceeds allowed time times warning percent.
// - Overload time beyond the full allowed time (8 s at 200% load) raises the overload alarm.
// - Code 0x11 drives the slot high on limit, comms error or undervoltage.
// - Code 0x19 drives the slot high in speed modes while speed error is below tolerance.
// - Code zero gives the slot no function.
module ssom_mapper #(
  parameter logic [`SSOM_OVL_W-1:0] OVL_ALLOW_CYC = `SSOM_OVL_ALLOW_CYC,
  parameter logic [`SSOM_OVL_W-1:0] MS_CYC        = `SSOM_MS_CYCLES
) (
  // Clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  rst_b,
  // Drive state, from pins
  input  wire logic                                  ctrl_power_ok,
  input  wire logic                                  main_power_ok,
  input  wire logic                                  servo_on,
  input  wire logic                                  torque_limit_active,
  input  wire logic                                  alarm_active,
  input  wire logic                                  warn_condition,
  input  wire logic                                  overload_active,
  // Mode and measurements, same clock
  input  wire ssom_pkg::ssom_mode_t                  control_mode,
  input  wire logic [`SSOM_SPD_W-1:0]                motor_speed,
  input  wire logic [`SSOM_SPD_W-1:0]                speed_command,
  input  wire logic [`SSOM_POS_W-1:0]                position_deviation,
  // Configuration
  input  wire logic [`SSOM_SPD_W-1:0]                zero_speed_threshold,
  input  wire logic [`SSOM_SPD_W-1:0]                target_speed_threshold,
  input  wire logic [`SSOM_POS_W-1:0]                in_position_range,
  input  wire logic [`SSOM_SPD_W-1:0]                speed_reached_tolerance,
  input  wire logic [6:0]                            overload_warning_percent,
  input  wire logic [`SSOM_DLY_W-1:0]                brake_on_delay_setting,
  input  wire logic [`SSOM_DLY_W-1:0]                brake_off_delay_setting,
  input  wire logic [`SSOM_SLOTS*`SSOM_SEL_W-1:0]    slot_select,
  // Status outputs
  output logic [`SSOM_SLOTS-1:0]                     slot_out,
  output logic                                       overload_alarm_code
);

  // Two-flop synchronisers for the pin-level status inputs
  logic [6:0] meta_reg, meta_next;
  logic [6:0] sync_reg, sync_next;
  always_comb begin
    meta_next = {ctrl_power_ok, main_power_ok, servo_on, torque_limit_active,
                 alarm_active, warn_condition, overload_active};
    sync_next = meta_reg;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_reg <= 7'h00;
      sync_reg <= 7'h00;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  logic s_ctrl_pwr, s_main_pwr, s_servo_on, s_tq_lim, s_alarm, s_warn, s_ovl;
  assign {s_ctrl_pwr, s_main_pwr, s_servo_on, s_tq_lim, s_alarm, s_warn, s_ovl} = sync_reg;

  // Millisecond tick for the brake delays
  logic [`SSOM_OVL_W-1:0] ms_cnt_reg, ms_cnt_next;
  logic                   ms_tick;
  always_comb begin
    ms_tick     = (ms_cnt_reg == MS_CYC - 32'h1);
    ms_cnt_next = ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
  end
  always_ff @(posedge clock) begin
    if (!rst_b) ms_cnt_reg <= 32'h0;
    else        ms_cnt_reg <= ms_cnt_next;
  end

  // Overload accumulation; decays while the overload is gone
  logic [`SSOM_OVL_W-1:0] ovl_acc_reg, ovl_acc_next;
  logic                   ovl_alarm_reg, ovl_alarm_next;
  logic                   pre_ovl_reg, pre_ovl_next;
  logic [`SSOM_OVL_W+7:0] warn_limit;
  logic [`SSOM_OVL_W+7:0] acc_scaled;
  always_comb begin
    ovl_acc_next = ovl_acc_reg;
    if (s_ovl && ovl_acc_reg != 32'hffffffff)
      ovl_acc_next = ovl_acc_reg + 32'h1;
    else if (!s_ovl && ovl_acc_reg != 32'h0)
      ovl_acc_next = ovl_acc_reg - 32'h1;
    // Compare acc*100 against allow*pct to avoid a divider
    acc_scaled   = 40'(ovl_acc_reg) * 40'(`SSOM_PCT_FULL);
    warn_limit   = 40'(OVL_ALLOW_CYC) * 40'(overload_warning_percent);
    pre_ovl_next = (acc_scaled > warn_limit);
    // Alarm latches until reset, like a drive fault
    ovl_alarm_next = ovl_alarm_reg | (ovl_acc_reg > OVL_ALLOW_CYC);
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ovl_acc_reg   <= 32'h0;
      ovl_alarm_reg <= 1'b0;
      pre_ovl_reg   <= 1'b0;
    end else begin
      ovl_acc_reg   <= ovl_acc_next;
      ovl_alarm_reg <= ovl_alarm_next;
      pre_ovl_reg   <= pre_ovl_next;
    end
  end
  assign overload_alarm_code = ovl_alarm_reg;

  // Brake release sequencer, delays counted in milliseconds
  ssom_pkg::ssom_brk_t    brk_reg, brk_next;
  logic [`SSOM_DLY_W-1:0] brk_cnt_reg, brk_cnt_next;
  always_comb begin
    brk_next     = brk_reg;
    brk_cnt_next = brk_cnt_reg;
    unique case (brk_reg)
      ssom_pkg::SSOM_BRK_HELD: begin
        if (s_servo_on) begin
          brk_next     = ssom_pkg::SSOM_BRK_ON_WAIT;
          brk_cnt_next = brake_on_delay_setting;
        end
      end
      ssom_pkg::SSOM_BRK_ON_WAIT: begin
        if (!s_servo_on) brk_next = ssom_pkg::SSOM_BRK_HELD;
        else if (brk_cnt_reg == 16'h0) brk_next = ssom_pkg::SSOM_BRK_FREE;
        else if (ms_tick) brk_cnt_next = brk_cnt_reg - 16'h1;
      end
      ssom_pkg::SSOM_BRK_FREE: begin
        if (!s_servo_on) begin
          brk_next     = ssom_pkg::SSOM_BRK_OFF_WAIT;
          brk_cnt_next = brake_off_delay_setting;
        end
      end
      ssom_pkg::SSOM_BRK_OFF_WAIT: begin
        // Engage early once the motor has slowed to zero speed
        if (s_servo_on) brk_next = ssom_pkg::SSOM_BRK_FREE;
        else if (brk_cnt_reg == 16'h0 || motor_speed < zero_speed_threshold)
          brk_next = ssom_pkg::SSOM_BRK_HELD;
        else if (ms_tick) brk_cnt_next = brk_cnt_reg - 16'h1;
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      brk_reg     <= ssom_pkg::SSOM_BRK_HELD;
      brk_cnt_reg <= 16'h0;
    end else begin
      brk_reg     <= brk_next;
      brk_cnt_reg <= brk_cnt_next;
    end
  end

  // Status functions shared by every slot
  logic any_alarm;
  logic drive_ready_flag, servo_enabled_flag, zero_speed_flag, target_speed_flag;
  logic in_position_flag, torque_limiting_flag, alarm_flag, brake_release_out;
  logic pre_overload_flag, warn_flag, speed_reached_flag;
  logic [`SSOM_SPD_W-1:0] spd_err;
  logic torque_mode, speed_mode;
  always_comb begin
    any_alarm   = s_alarm | ovl_alarm_reg;
    torque_mode = (control_mode == ssom_pkg::SSOM_MODE_T) || (control_mode == ssom_pkg::SSOM_MODE_TZ);
    speed_mode  = (control_mode == ssom_pkg::SSOM_MODE_S) || (control_mode == ssom_pkg::SSOM_MODE_SZ);
    spd_err     = (motor_speed > speed_command) ? motor_speed - speed_command
                                                : speed_command - motor_speed;
    drive_ready_flag     = s_ctrl_pwr & s_main_pwr & ~any_alarm;
    servo_enabled_flag   = s_servo_on & ~any_alarm;
    zero_speed_flag      = motor_speed < zero_speed_threshold;
    target_speed_flag    = motor_speed > target_speed_threshold;
    in_position_flag     = (control_mode == ssom_pkg::SSOM_MODE_PT)
                         && (position_deviation < in_position_range);
    torque_limiting_flag = s_tq_lim & ~torque_mode;
    alarm_flag           = any_alarm;
    brake_release_out    = (brk_reg == ssom_pkg::SSOM_BRK_FREE)
                         || (brk_reg == ssom_pkg::SSOM_BRK_OFF_WAIT);
    pre_overload_flag    = pre_ovl_reg;
    warn_flag            = s_warn;
    speed_reached_flag   = speed_mode && (spd_err < speed_reached_tolerance);
  end

  // Per-slot decode, registered so outputs are glitch-free levels
  logic [`SSOM_SLOTS-1:0] slot_reg, slot_next;
  genvar g;
  generate
    for (g = 0; g < `SSOM_SLOTS; g++) begin : g_slot
      logic [`SSOM_SEL_W-1:0] sel;
      assign sel = slot_select[g*`SSOM_SEL_W +: `SSOM_SEL_W];
      always_comb begin
        case (sel)
          `SSOM_SEL_READY:    slot_next[g] = drive_ready_flag;
          `SSOM_SEL_SERVO_ON: slot_next[g] = servo_enabled_flag;
          `SSOM_SEL_ZERO_SPD: slot_next[g] = zero_speed_flag;
          `SSOM_SEL_TGT_SPD:  slot_next[g] = target_speed_flag;
          `SSOM_SEL_IN_POS:   slot_next[g] = in_position_flag;
          `SSOM_SEL_TQ_LIMIT: slot_next[g] = torque_limiting_flag;
          `SSOM_SEL_ALARM:    slot_next[g] = alarm_flag;
          `SSOM_SEL_BRAKE:    slot_next[g] = brake_release_out;
          `SSOM_SEL_PRE_OVL:  slot_next[g] = pre_overload_flag;
          `SSOM_SEL_WARN:     slot_next[g] = warn_flag;
          `SSOM_SEL_SPD_OK:   slot_next[g] = speed_reached_flag;
          `SSOM_SEL_NONE:     slot_next[g] = 1'b0;
          default:            slot_next[g] = 1'b0;
        endcase
      end
    end
  endgenerate
  always_ff @(posedge clock) begin
    if (!rst_b) slot_reg <= 6'h00;
    else        slot_reg <= slot_next;
  end
  assign slot_out = slot_reg;

endmodule : ssom_mapper
`default_nettype wire

// ===== shared/ssom_cfg.svh
// Constants for the servo status output mapper
`ifndef SSOM_CFG_SVH
`define SSOM_CFG_SVH
`define SSOM_SLOTS         6
`define SSOM_SEL_W         8
`define SSOM_SPD_W         16
`define SSOM_POS_W         24
`define SSOM_DLY_W         16
`define SSOM_OVL_W         32
`define SSOM_SEL_NONE      8'h00
`define SSOM_SEL_READY     8'h01
`define SSOM_SEL_SERVO_ON  8'h02
`define SSOM_SEL_ZERO_SPD  8'h03
`define SSOM_SEL_TGT_SPD   8'h04
`define SSOM_SEL_IN_POS    8'h05
`define SSOM_SEL_TQ_LIMIT  8'h06
`define SSOM_SEL_ALARM     8'h07
`define SSOM_SEL_BRAKE     8'h08
`define SSOM_SEL_PRE_OVL   8'h10
`define SSOM_SEL_WARN      8'h11
`define SSOM_SEL_SPD_OK    8'h19
`define SSOM_CLK_HZ        25000000
`define SSOM_MS_CYCLES     (`SSOM_CLK_HZ / 1000)
`define SSOM_OVL_ALLOW_MS  8000
`define SSOM_OVL_ALLOW_CYC (`SSOM_OVL_ALLOW_MS * `SSOM_MS_CYCLES)
`define SSOM_PCT_FULL      100
`endif

// ===== shared/ssom_pkg.sv
// Types for the servo status output mapper
package ssom_pkg;
  typedef enum logic [2:0] {
    SSOM_MODE_PT = 3'h0,
    SSOM_MODE_PR = 3'h1,
    SSOM_MODE_S  = 3'h2,
    SSOM_MODE_T  = 3'h3,
    SSOM_MODE_SZ = 3'h4,
    SSOM_MODE_TZ = 3'h5
  } ssom_mode_t;
  typedef enum logic [1:0] {
    SSOM_BRK_HELD    = 2'h0,
    SSOM_BRK_ON_WAIT = 2'h1,
    SSOM_BRK_FREE    = 2'h2,
    SSOM_BRK_OFF_WAIT = 2'h3
  } ssom_brk_t;
endpackage : ssom_pkg

// ===== testbench/ssom_ctrl_model.sv
// External controller that samples the status levels
`timescale 1ns/10ps
`default_nettype none
module ssom_ctrl_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Status levels seen at the pins
  input  wire logic [5:0] status,
  output var  logic [5:0] seen_reg
);
  // Plain level reader, so nothing is ever acknowledged back
  always_ff @(posedge clock) begin
    seen_reg <= rst_b ? status : 6'h00;
  end
endmodule : ssom_ctrl_model
`default_nettype wire

// ===== testbench/ssom_mapper_checker.sv
// Port checker for the servo status output mapper
`timescale 1ns/10ps
`default_nettype none
module ssom_mapper_checker #(
  parameter logic [31:0] OVL_ALLOW_CYC = 32'h3e8
) (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 rst_b,
  // Watched inputs
  input wire logic                 torque_limit_active,
  input wire logic                 overload_active,
  input wire ssom_pkg::ssom_mode_t control_mode,
  input wire logic [15:0]          motor_speed,
  input wire logic [15:0]          speed_command,
  input wire logic [23:0]          position_deviation,
  input wire logic [15:0]          zero_speed_threshold,
  input wire logic [15:0]          target_speed_threshold,
  input wire logic [23:0]          in_position_range,
  input wire logic [15:0]          speed_reached_tolerance,
  input wire logic [47:0]          slot_select,
  // Watched outputs
  input wire logic [5:0]           slot_out,
  input wire logic                 overload_alarm_code
);
  logic [31:0] ovl_cnt_reg, ovl_cnt_next;
  logic [15:0] sp_err;
  logic        zero_ok, tgt_ok, pos_ok, spd_ok, no_fn;
  // Raw overload cycles bound the design's accumulator from above
  always_comb begin
    ovl_cnt_next = rst_b ? ovl_cnt_reg + {31'h0, overload_active} : 32'h0;
    sp_err = motor_speed > speed_command ? motor_speed - speed_command : speed_command - motor_speed;
    zero_ok = motor_speed < zero_speed_threshold;
    tgt_ok = motor_speed > target_speed_threshold;
    pos_ok = control_mode == ssom_pkg::SSOM_MODE_PT && position_deviation < in_position_range;
    spd_ok = (control_mode == ssom_pkg::SSOM_MODE_S || control_mode == ssom_pkg::SSOM_MODE_SZ)
             && sp_err < speed_reached_tolerance;
    no_fn = !(slot_select[39:32] inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                         8'h10, 8'h11, 8'h19});
  end
  always_ff @(posedge clock) begin
    ovl_cnt_reg <= ovl_cnt_next;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  zero_spd_a: assert property (slot_select[7:0] == 8'h03 |=> slot_out[0] == $past(zero_ok))
    else $error("zero speed slot wrong");
  tgt_spd_a: assert property (slot_select[15:8] == 8'h04 |=> slot_out[1] == $past(tgt_ok))
    else $error("target speed slot wrong");
  in_pos_a: assert property (slot_select[23:16] == 8'h05 |=> slot_out[2] == $past(pos_ok))
    else $error("in position slot wrong");
  spd_ok_a: assert property (slot_select[31:24] == 8'h19 |=> slot_out[3] == $past(spd_ok))
    else $error("speed reached slot wrong");
  no_func_a: assert property (no_fn |=> !slot_out[4])
    else $error("slot without function went high");
  tq_limit_a: assert property ($rose(slot_out[5]) && slot_select[47:40] == 8'h06 |-> $past(torque_limit_active, 3))
    else $error("torque limit slot rose without cause");
  alarm_sticky_a: assert property (overload_alarm_code |=> overload_alarm_code)
    else $error("overload alarm dropped");
  alarm_cause_a: assert property ($rose(overload_alarm_code) |-> ovl_cnt_reg > OVL_ALLOW_CYC)
    else $error("overload alarm too early");
  // Main scenarios reached
  cov_alarm_c: cover property ($rose(overload_alarm_code));
  cov_brake_c: cover property (slot_select[7:0] == 8'h08 && $rose(slot_out[0]));
  cov_tq_c: cover property (slot_select[47:40] == 8'h06 && $rose(slot_out[5]));
endmodule : ssom_mapper_checker
bind ssom_mapper ssom_mapper_checker #(.OVL_ALLOW_CYC(OVL_ALLOW_CYC)) i_ssom_mapper_checker (.clock, .rst_b,
  .torque_limit_active, .overload_active, .control_mode, .motor_speed, .speed_command, .position_deviation,
  .zero_speed_threshold, .target_speed_threshold, .in_position_range, .speed_reached_tolerance, .slot_select,
  .slot_out, .overload_alarm_code);
`default_nettype wire

// ===== testbench/test_servo_status_output_mapper.sv
// Self-checking bench for the servo status output mapper
`timescale 1ns/10ps
`default_nettype none
module test_servo_status_output_mapper;
  logic clock = 0, rst_b = 0, ctrl_power_ok = 0, main_power_ok = 0, servo_on = 0;
  logic torque_limit_active = 0, alarm_active = 0, warn_condition = 0, overload_active = 0;
  ssom_pkg::ssom_mode_t control_mode = ssom_pkg::SSOM_MODE_PT;
  logic [15:0] motor_speed = 0, speed_command = 0, zero_speed_threshold = 0, target_speed_threshold = 0;
  logic [15:0] speed_reached_tolerance = 0, brake_on_delay_setting = 0, brake_off_delay_setting = 0;
  logic [23:0] position_deviation = 0, in_position_range = 0;
  logic [6:0]  overload_warning_percent = 7'h3c;
  logic [47:0] slot_select = 0;
  logic [5:0]  slot_out, seen_reg;
  logic        overload_alarm_code;
  logic [7:0]  codes [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h11, 8'h19,
                              8'h09, 8'h12, 8'hff};
  int n_mismatch = 0, checks = 0, cyc = 0, alm = 0, pre = 0, brk = 0;
  ssom_mapper #(.OVL_ALLOW_CYC(32'h3e8), .MS_CYC(32'ha)) i_ssom_mapper (.clock, .rst_b, .ctrl_power_ok,
    .main_power_ok, .servo_on, .torque_limit_active, .alarm_active, .warn_condition, .overload_active,
    .control_mode, .motor_speed, .speed_command, .position_deviation, .zero_speed_threshold,
    .target_speed_threshold, .in_position_range, .speed_reached_tolerance, .overload_warning_percent,
    .brake_on_delay_setting, .brake_off_delay_setting, .slot_select, .slot_out, .overload_alarm_code);
  ssom_ctrl_model i_ssom_ctrl_model (.clock, .rst_b, .status(slot_out), .seen_reg);
  // Clock and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Reference level for one code, from settled inputs
  function automatic logic expv(input logic [7:0] c);
    int m, d;
    m = control_mode;
    d = motor_speed > speed_command ? motor_speed - speed_command : speed_command - motor_speed;
    case (c)
      8'h01: return ctrl_power_ok && main_power_ok && !alarm_active && alm == 0;
      8'h02: return servo_on && !alarm_active && alm == 0;
      8'h03: return motor_speed < zero_speed_threshold;
      8'h04: return motor_speed > target_speed_threshold;
      8'h05: return m == 0 && position_deviation < in_position_range;
      8'h06: return torque_limit_active && m != 3 && m != 5;
      8'h07: return alarm_active || alm != 0;
      8'h08: return brk != 0;
      8'h10: return pre != 0;
      8'h11: return warn_condition;
      8'h19: return (m == 2 || m == 4) && d < speed_reached_tolerance;
      default: return 1'b0;
    endcase
  endfunction : expv
  task automatic cmp(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t status level differs", $time);
    end
  endtask : cmp
  task automatic chk_slots();
    for (int g = 0; g < 6; g++) begin
      cmp(slot_out[g], expv(slot_select[8*g+:8]));
      // Controller sees the settled level one edge later
      cmp(seen_reg[g], slot_out[g]);
    end
  endtask : chk_slots
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(32'h783d1a4c));
    step(20);
    rst_b = 1;
    // Random sweep of codes, modes and levels
    for (int i = 0; i < 60; i++) begin
      {ctrl_power_ok, main_power_ok, servo_on, torque_limit_active, alarm_active, warn_condition} = 6'($urandom);
      control_mode = ssom_pkg::ssom_mode_t'($urandom_range(5));
      {motor_speed, speed_command} = {16'($urandom_range(300)), 16'($urandom_range(300))};
      {zero_speed_threshold, target_speed_threshold} = {16'($urandom_range(300)), 16'($urandom_range(300))};
      speed_reached_tolerance = 16'($urandom_range(100));
      {position_deviation, in_position_range} = {24'($urandom_range(50)), 24'($urandom_range(50))};
      for (int g = 0; g < 6; g++) slot_select[8*g+:8] = codes[$urandom_range(13)];
      if (i == 0) slot_select = {8'h06, 8'h09, 8'h19, 8'h05, 8'h04, 8'h03};
      step(6);
      chk_slots();
    end
    // Brake release after both delays, then early engage by low speed
    {alarm_active, servo_on, motor_speed, zero_speed_threshold} = {2'b00, 16'h64, 16'ha};
    {brake_on_delay_setting, brake_off_delay_setting, slot_select} = {16'h2, 16'h3, {6{8'h08}}};
    // Long enough for any off-delay left over from the sweep to run out
    step(60);
    servo_on = 1;
    step(10);
    chk_slots();
    step(30);
    brk = 1;
    chk_slots();
    servo_on = 0;
    step(8);
    chk_slots();
    step(40);
    brk = 0;
    chk_slots();
    servo_on = 1;
    step(45);
    {servo_on, motor_speed} = 17'h0;
    step(8);
    chk_slots();
    // Overload warning, then latched alarm, cleared by reset
    {overload_active, slot_select} = {1'b1, 16'h0, 8'h02, 8'h01, 8'h07, 8'h10};
    step(660);
    pre = 1;
    chk_slots();
    cmp(overload_alarm_code, 1'b0);
    step(400);
    alm = 1;
    chk_slots();
    overload_active = 0;
    step(20);
    cmp(overload_alarm_code, 1'b1);
    rst_b = 0;
    step(3);
    {rst_b, alm, pre} = {1'b1, 32'h0, 32'h0};
    step(6);
    chk_slots();
    cmp(overload_alarm_code, 1'b0);
    wrap_up();
  end
endmodule : test_servo_status_output_mapper
`default_nettype wire
